// >>> include/sprc_pkg.sv
// Package for the software peripheral reset control block.
// Assumes a 32-bit register port and a 20 MHz system clock.
package sprc_pkg;

  // Register byte offsets
  localparam logic [11:0] SPRC_CORE_CHIP_OFS = 12'h008;
  localparam logic [11:0] SPRC_PERIPH_OFS = 12'h00c;
  localparam logic [11:0] SPRC_STATUS_OFS = 12'h004;
  localparam int SPRC_ADDR_W = 12;

  // Core/chip register fields
  localparam int SPRC_CHIP_BIT = 0;
  localparam int SPRC_CPU_BIT = 1;
  localparam int SPRC_DMA_BIT = 2;
  localparam logic [31:0] SPRC_CORE_MASK = 32'h0000_0007;

  // Peripheral register fields
  localparam int SPRC_TIMER0_BIT = 6;
  localparam int SPRC_TIMER1_BIT = 7;
  localparam int SPRC_TWI_BIT = 8;
  localparam int SPRC_SPI_BIT = 12;
  localparam int SPRC_SPK_BIT = 13;
  localparam int SPRC_UART_BIT = 16;
  localparam int SPRC_BIQ_BIT = 18;
  localparam int SPRC_CRC_BIT = 19;
  localparam int SPRC_PWM_BIT = 20;
  localparam int SPRC_CMP_BIT = 22;
  localparam int SPRC_ADC_BIT = 28;
  localparam int SPRC_AUDIO_BIT = 29;
  localparam int SPRC_ANA_BIT = 30;
  localparam logic [31:0] SPRC_PERIPH_MASK = 32'h705d_31c0;

  // Status register field
  localparam int SPRC_CPU_FLAG_BIT = 7;

  // Reset values
  localparam logic [31:0] SPRC_REG_RST = 32'h0000_0000;

  // One-shot hold, in clock cycles
  localparam int SPRC_ONESHOT_CYC = 2;
  localparam logic [1:0] SPRC_ONESHOT_LOAD = 2'(SPRC_ONESHOT_CYC);

  // Register port request
  typedef struct packed {
    logic [SPRC_ADDR_W-1:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } sprc_req_s;

  // One-shot sequencer states
  typedef enum logic [1:0] {
    SPRC_IDLE = 2'b00,
    SPRC_HOLD = 2'b01
  } sprc_state_e;

endpackage : sprc_pkg

// >>> design/sprc_reset_ctrl.sv
// Software reset control: DMA level reset, CPU and chip one-shots,
// per-peripheral level resets. Lock state comes from the lock-key logic.
// Lock level arrives on CLK_SYS, so it needs no synchroniser.
//
// Operation
// - DMA bit holds DMA block in reset
// - CPU one-shot resets kernel, clears after two
// - Chip one-shot resets chip, clears after two
// - Chip one-shot acts like power-on reset
// - Protected one-shots ignored while registers locked
// - Peripheral bit drives matching peripheral reset
// - Upper peripheral bit mapping 30 down 16
// - Lower peripheral bit mapping 13 down 6
// - Both registers clear to zero on reset
// - CPU one-shot sets sticky source flag
//
// Implementation choice: strobed register access.
`timescale 1ns/1ps
`default_nettype none

module sprc_reset_ctrl
  import sprc_pkg::*;
#(
  // One-shot hold length, in clock cycles
  parameter int ONESHOT_CYC = SPRC_ONESHOT_CYC
)
(
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RST,
  // Register port
  input wire logic [SPRC_ADDR_W-1:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  // Lock state from lock-key logic (same clock)
  input wire logic REGS_UNLOCKED,
  // Core resets
  output logic DMA_BLOCK_RESET,
  output logic CPU_ONESHOT_RESET,
  output logic WHOLE_CHIP_ONESHOT_RESET,
  // Peripheral resets
  output logic ANALOG_CTRL_RESET,
  output logic AUDIO_SERIAL_RESET,
  output logic CONVERTER_CTRL_RESET,
  output logic COMPARATOR_RESET,
  output logic PULSE_WIDTH_CTRL_RESET,
  output logic CHECKSUM_BLOCK_RESET,
  output logic BIQUAD_FILTER_RESET,
  output logic SERIAL_PORT_RESET,
  output logic SPEAKER_DRIVER_RESET,
  output logic SPI_CTRL_RESET,
  output logic TWO_WIRE_CTRL_RESET,
  output logic TIMER_ONE_RESET,
  output logic TIMER_ZERO_RESET,
  // Reset source flag
  output logic CPU_RESET_SOURCE_FLAG
);

  ////////////////////////////////////////////////////////////////////////
  // Elaboration checks and derived constants

  // Counter load for a hold of ONESHOT_CYC cycles
  localparam logic [1:0] ONESHOT_LOAD = 2'(ONESHOT_CYC - 1);

  // Bits that each register really maps
  localparam logic [31:0] CORE_MAP =
    (32'h0000_0001 << SPRC_DMA_BIT) | (32'h0000_0001 << SPRC_CPU_BIT) | (32'h0000_0001 << SPRC_CHIP_BIT);
  localparam logic [31:0] PERIPH_UPPER_MAP =
    (32'h0000_0001 << SPRC_ANA_BIT) | (32'h0000_0001 << SPRC_AUDIO_BIT) | (32'h0000_0001 << SPRC_ADC_BIT) |
    (32'h0000_0001 << SPRC_CMP_BIT) | (32'h0000_0001 << SPRC_PWM_BIT) | (32'h0000_0001 << SPRC_CRC_BIT) |
    (32'h0000_0001 << SPRC_BIQ_BIT) | (32'h0000_0001 << SPRC_UART_BIT);
  localparam logic [31:0] PERIPH_LOWER_MAP =
    (32'h0000_0001 << SPRC_SPK_BIT) | (32'h0000_0001 << SPRC_SPI_BIT) | (32'h0000_0001 << SPRC_TWI_BIT) |
    (32'h0000_0001 << SPRC_TIMER1_BIT) | (32'h0000_0001 << SPRC_TIMER0_BIT);

  // Hold must fit the 2-bit counter
  if (ONESHOT_CYC < 1 || ONESHOT_CYC > 4)
  begin : g_bad_hold
    $error("ONESHOT_CYC out of range 1 to 4");
  end

  // Masks must match the field map, or a peripheral reset would be lost
  if (CORE_MAP != SPRC_CORE_MASK || (PERIPH_UPPER_MAP | PERIPH_LOWER_MAP) != SPRC_PERIPH_MASK)
  begin : g_bad_map
    $error("register mask differs from field map");
  end

  ////////////////////////////////////////////////////////////////////////
  // Request bundle and decode

  sprc_req_s req;
  assign req = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};

  function automatic logic hit(input logic [SPRC_ADDR_W-1:0] a, input logic [SPRC_ADDR_W-1:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  // Places a one-bit field at its position in a word
  function automatic logic [31:0] at_bit(input logic v, input int pos);
    at_bit = 32'(v) << pos;
  endfunction : at_bit

  wire wr_core = req.wr && hit(req.addr, SPRC_CORE_CHIP_OFS);
  wire wr_periph = req.wr && hit(req.addr, SPRC_PERIPH_OFS);
  wire wr_status = req.wr && hit(req.addr, SPRC_STATUS_OFS);

  ////////////////////////////////////////////////////////////////////////
  // State

  logic dma_r;
  logic cpu_r;
  logic chip_r;
  logic [1:0] cpu_cnt_r;
  logic [1:0] chip_cnt_r;
  sprc_state_e cpu_st_r;
  sprc_state_e chip_st_r;
  logic [31:0] periph_r;
  logic cpu_flag_r;
  logic [31:0] rdata_r;

  // Protected one-shot triggers, dropped while locked
  wire cpu_fire = wr_core && REGS_UNLOCKED && req.wdata[SPRC_CPU_BIT];
  wire chip_fire = wr_core && REGS_UNLOCKED && req.wdata[SPRC_CHIP_BIT];

  // Only an idle one-shot starts; a repeat write mid-pulse is dropped
  wire cpu_start = cpu_fire && (cpu_st_r == SPRC_IDLE);
  wire chip_start = chip_fire && (chip_st_r == SPRC_IDLE);

  // DMA level follows every core write, locked or not
  wire dma_nxt = wr_core ? req.wdata[SPRC_DMA_BIT] : dma_r;

  // Peripheral levels; reserved bits never reach a register
  wire [31:0] periph_nxt = wr_periph ? (req.wdata & SPRC_PERIPH_MASK) : periph_r;

  // Source flag: a start sets it, writing 1 clears it, set wins
  wire clr_flag = wr_status && req.wdata[SPRC_CPU_FLAG_BIT];
  wire cpu_flag_nxt = cpu_start | (cpu_flag_r & ~clr_flag);

  // Read decode per register
  wire rd_core = req.rd && hit(req.addr, SPRC_CORE_CHIP_OFS);
  wire rd_periph = req.rd && hit(req.addr, SPRC_PERIPH_OFS);
  wire rd_status = req.rd && hit(req.addr, SPRC_STATUS_OFS);

  // Read words, reserved bits zero; one-shot bits read live
  wire [31:0] core_rd = (at_bit(dma_r, SPRC_DMA_BIT) | at_bit(cpu_r, SPRC_CPU_BIT) | at_bit(chip_r, SPRC_CHIP_BIT)) &
    SPRC_CORE_MASK;
  wire [31:0] stat_rd = at_bit(cpu_flag_r, SPRC_CPU_FLAG_BIT);

  // Read select; idle or unmapped cycles return zero
  wire [31:0] rdata_nxt =
    rd_core ? core_rd :
    rd_periph ? periph_r :
    rd_status ? stat_rd : 32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////
  // Level registers

  // DMA and peripheral levels
  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      dma_r <= SPRC_REG_RST[SPRC_DMA_BIT];
      periph_r <= SPRC_REG_RST;
    end
    else
    begin
      dma_r <= dma_nxt;
      periph_r <= periph_nxt;
    end
  end

  // Source flag
  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
      cpu_flag_r <= 1'b0;
    else
      cpu_flag_r <= cpu_flag_nxt;
  end

  // Read data, one cycle after the strobe
  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
      rdata_r <= 32'h0000_0000;
    else
      rdata_r <= rdata_nxt;
  end

  ////////////////////////////////////////////////////////////////////////
  // CPU one-shot: high two cycles then self-clears

  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      cpu_st_r <= SPRC_IDLE;
      cpu_r <= 1'b0;
      cpu_cnt_r <= 2'h0;
    end
    else
    begin
      case (cpu_st_r)
        SPRC_IDLE:
        begin
          if (cpu_start)
          begin
            cpu_st_r <= SPRC_HOLD;
            cpu_r <= 1'b1;
            cpu_cnt_r <= ONESHOT_LOAD;
          end
        end
        SPRC_HOLD:
        begin
          if (cpu_cnt_r == 2'h0)
          begin
            cpu_st_r <= SPRC_IDLE;
            cpu_r <= 1'b0;
          end
          else
            cpu_cnt_r <= cpu_cnt_r - 2'h1;
        end
        default:
        begin
          cpu_st_r <= SPRC_IDLE;
          cpu_r <= 1'b0;
          cpu_cnt_r <= 2'h0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Chip one-shot: high two cycles then self-clears

  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      chip_st_r <= SPRC_IDLE;
      chip_r <= 1'b0;
      chip_cnt_r <= 2'h0;
    end
    else
    begin
      case (chip_st_r)
        SPRC_IDLE:
        begin
          if (chip_start)
          begin
            chip_st_r <= SPRC_HOLD;
            chip_r <= 1'b1;
            chip_cnt_r <= ONESHOT_LOAD;
          end
        end
        SPRC_HOLD:
        begin
          if (chip_cnt_r == 2'h0)
          begin
            chip_st_r <= SPRC_IDLE;
            chip_r <= 1'b0;
          end
          else
            chip_cnt_r <= chip_cnt_r - 2'h1;
        end
        default:
        begin
          chip_st_r <= SPRC_IDLE;
          chip_r <= 1'b0;
          chip_cnt_r <= 2'h0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs, all straight from flip-flops

  // Read data, zero outside the answer cycle
  assign RDATA = rdata_r;

  // Core resets
  assign DMA_BLOCK_RESET = dma_r;
  assign CPU_ONESHOT_RESET = cpu_r;
  assign WHOLE_CHIP_ONESHOT_RESET = chip_r;

  // Source flag
  assign CPU_RESET_SOURCE_FLAG = cpu_flag_r;

  // Upper peripheral map
  assign ANALOG_CTRL_RESET = periph_r[SPRC_ANA_BIT];
  assign AUDIO_SERIAL_RESET = periph_r[SPRC_AUDIO_BIT];
  assign CONVERTER_CTRL_RESET = periph_r[SPRC_ADC_BIT];
  assign COMPARATOR_RESET = periph_r[SPRC_CMP_BIT];
  assign PULSE_WIDTH_CTRL_RESET = periph_r[SPRC_PWM_BIT];
  assign CHECKSUM_BLOCK_RESET = periph_r[SPRC_CRC_BIT];
  assign BIQUAD_FILTER_RESET = periph_r[SPRC_BIQ_BIT];
  assign SERIAL_PORT_RESET = periph_r[SPRC_UART_BIT];

  // Lower peripheral map
  assign SPEAKER_DRIVER_RESET = periph_r[SPRC_SPK_BIT];
  assign SPI_CTRL_RESET = periph_r[SPRC_SPI_BIT];
  assign TWO_WIRE_CTRL_RESET = periph_r[SPRC_TWI_BIT];
  assign TIMER_ONE_RESET = periph_r[SPRC_TIMER1_BIT];
  assign TIMER_ZERO_RESET = periph_r[SPRC_TIMER0_BIT];

endmodule : sprc_reset_ctrl

`default_nettype wire

// >>> dv/sprc_reset_ctrl_assertions.sv
// Port checker for the reset control block.
// Assumes one clock and a sync active-high reset.
`timescale 1ns/1ps
`default_nettype none
module sprc_chk
  import sprc_pkg::*;
(
  // Clock, reset, register port
  input wire logic CLK_SYS, RST, WR, RD, REGS_UNLOCKED,
  input wire logic [SPRC_ADDR_W-1:0] ADDR,
  input wire logic [31:0] WDATA, RDATA,
  // Reset outputs
  input wire logic DMA_BLOCK_RESET, CPU_ONESHOT_RESET, WHOLE_CHIP_ONESHOT_RESET,
  input wire logic TIMER_ZERO_RESET, ANALOG_CTRL_RESET, CPU_RESET_SOURCE_FLAG
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  // Write decode
  wire logic wc = WR && ADDR == SPRC_CORE_CHIP_OFS;
  wire logic wp = WR && ADDR == SPRC_PERIPH_OFS;
  wire logic cpu = CPU_ONESHOT_RESET;
  wire logic chp = WHOLE_CHIP_ONESHOT_RESET;
  AST_DMA: assert property (wc |=> DMA_BLOCK_RESET == $past(WDATA[2])) else $error("dma");
  AST_CPU: assert property (wc && WDATA[1] && REGS_UNLOCKED && !cpu |=> cpu[*2] ##1 !cpu) else $error("cpu");
  AST_CHIP: assert property (wc && WDATA[0] && REGS_UNLOCKED && !chp |=> chp[*2] ##1 !chp) else $error("chip");
  AST_LOCK: assert property (wc && !REGS_UNLOCKED && !cpu && !chp |=> !cpu && !chp) else $error("lock");
  AST_PER: assert property (wp |=> TIMER_ZERO_RESET == $past(WDATA[6]) && ANALOG_CTRL_RESET == $past(WDATA[30]))
    else $error("periph");
  AST_FLAG: assert property ($rose(cpu) |-> CPU_RESET_SOURCE_FLAG) else $error("flag");
  AST_RDZ: assert property (!RD |=> RDATA == 32'h0) else $error("rdata idle");
  AST_RSV: assert property (RD && ADDR == SPRC_PERIPH_OFS |=> (RDATA & ~SPRC_PERIPH_MASK) == 32'h0)
    else $error("reserved");
  AST_CLR: assert property ($fell(RST) |-> !DMA_BLOCK_RESET && !cpu && !chp && !TIMER_ZERO_RESET) else $error("clr");
  // Main scenarios
  cover property ($rose(cpu));
  cover property ($rose(chp));
  cover property (wc && !REGS_UNLOCKED);
  cover property ($fell(RST));
endmodule : sprc_chk
bind sprc_reset_ctrl sprc_chk u_chk (.CLK_SYS, .RST, .WR, .RD, .REGS_UNLOCKED, .ADDR, .WDATA, .RDATA,
  .DMA_BLOCK_RESET, .CPU_ONESHOT_RESET, .WHOLE_CHIP_ONESHOT_RESET, .TIMER_ZERO_RESET,
  .ANALOG_CTRL_RESET, .CPU_RESET_SOURCE_FLAG);
`default_nettype wire

// >>> dv/tb_top.sv
// Bench for the reset control block over its register port.
// Assumes the checker file is compiled beside it.
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import sprc_pkg::*;
;
  logic clk = 0, rst = 1, wr = 0, rd = 0, unl = 0;
  logic [11:0] a = 12'h0;
  logic [31:0] d = 32'h0;
  int n_mismatch = 0, n_checks = 0;
  wire logic dma, cpu, chp, flag, ana, aud, adc, cmp, pwm, crc, biq, uar, spk, spi, twi, t1, t0;
  wire logic [31:0] rdat;
  // Peripheral resets at their bit positions
  wire logic [31:0] pv = {1'h0, ana, aud, adc, 5'h0, cmp, 1'h0, pwm, crc, biq, 1'h0, uar, 2'h0, spk, spi, 3'h0, twi, t1,
    t0, 6'h0};
  always #25 clk = ~clk;
  sprc_reset_ctrl dut (.CLK_SYS(clk), .RST(rst), .ADDR(a), .WDATA(d), .WR(wr), .RD(rd), .RDATA(rdat),
    .REGS_UNLOCKED(unl), .DMA_BLOCK_RESET(dma), .CPU_ONESHOT_RESET(cpu), .WHOLE_CHIP_ONESHOT_RESET(chp),
    .ANALOG_CTRL_RESET(ana), .AUDIO_SERIAL_RESET(aud), .CONVERTER_CTRL_RESET(adc), .COMPARATOR_RESET(cmp),
    .PULSE_WIDTH_CTRL_RESET(pwm), .CHECKSUM_BLOCK_RESET(crc), .BIQUAD_FILTER_RESET(biq), .SERIAL_PORT_RESET(uar),
    .SPEAKER_DRIVER_RESET(spk), .SPI_CTRL_RESET(spi), .TWO_WIRE_CTRL_RESET(twi), .TIMER_ONE_RESET(t1),
    .TIMER_ZERO_RESET(t0), .CPU_RESET_SOURCE_FLAG(flag));
  ////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // One-cycle write strobe
  task automatic wr32(input logic [11:0] ad, input logic [31:0] wd);
    @(posedge clk);
    a <= ad;
    d <= wd;
    wr <= 1'h1;
    @(posedge clk);
    wr <= 1'h0;
    #1;
  endtask : wr32
  // Read, data compared the cycle after
  task automatic rd32(input logic [11:0] ad, input logic [31:0] e, input string n);
    @(posedge clk);
    a <= ad;
    rd <= 1'h1;
    @(posedge clk);
    rd <= 1'h0;
    #1 chk(n, e, rdat);
  endtask : rd32
  // One-shot: high two cycles, then low
  task automatic shot(input logic [1:0] s);
    wr32(SPRC_CORE_CHIP_OFS, {30'h0, s});
    for (int i = 0; i < 3; i++)
    begin
      chk("oneshot", (i < 2) ? s : 2'h0, {cpu, chp});
      @(posedge clk);
      #1;
    end
  endtask : shot
  task automatic summarize;
    if (n_mismatch == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : summarize
  ////////////////////////////////////////////////////////////
  initial
  begin
    repeat (20) @(posedge clk);
    rst <= 1'h0;
    rd32(SPRC_CORE_CHIP_OFS, 32'h0, "core rst");
    rd32(SPRC_PERIPH_OFS, 32'h0, "per rst");
    wr32(SPRC_PERIPH_OFS, 32'hffff_ffff);
    chk("per out", SPRC_PERIPH_MASK, pv);
    rd32(SPRC_PERIPH_OFS, SPRC_PERIPH_MASK, "per rd");
    wr32(SPRC_PERIPH_OFS, 32'h0);
    chk("per off", 32'h0, pv);
    wr32(SPRC_CORE_CHIP_OFS, 32'h7);
    chk("locked", 32'h4, {dma, cpu, chp});
    rd32(SPRC_CORE_CHIP_OFS, 32'h4, "core rd");
    wr32(SPRC_PERIPH_OFS, SPRC_PERIPH_MASK);
    chk("per set", SPRC_PERIPH_MASK, pv);
    @(posedge clk);
    rst <= 1'h1;
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    #1 chk("mid rst", 32'h0, {pv[31:3], dma, cpu, chp});
    rd32(SPRC_PERIPH_OFS, 32'h0, "per mid rst");
    @(posedge clk);
    unl <= 1'h1;
    shot(2'h2);
    rd32(SPRC_STATUS_OFS, 32'h80, "flag");
    wr32(SPRC_STATUS_OFS, 32'h80);
    chk("flag clr", 32'h0, flag);
    shot(2'h1);
    chk("dma off", 32'h0, dma);
    rd32(12'h010, 32'h0, "unmapped");
    summarize();
  end
  // Watchdog
  initial
  begin
    #50us;
    n_mismatch++;
    summarize();
  end
endmodule : tb_top
`default_nettype wire
